// File: verilog/sas_sequencer.sv
/*
 SAR converter sequencer: AXI4-Lite registers, conversion sequencing, flags.
 Assumes the analog sample-hold, comparator and ladder DAC sit outside, and
 that standby_req is high while the core is in stop, slow or sleep standby.
// Notes on behaviour
// RULE_01: Start bit begins conversion, then self-clears
// RULE_02: Mode 00 off, 01 single, 11 repeat
// RULE_03: Input disable bit gates analog inputs
// RULE_04: Channel field code n selects input n
// RULE_05: Software changes channel only while idle
// RULE_06: Software restarts only after end flag
// RULE_07: Standby resets control registers, blocks writes
// RULE_08: Ladder bit: connect during conversion or always
// RULE_09: Time field picks 39 to 1248 periods
// RULE_10: Software writes bit0 zero, bit4 one
// RULE_11: Control two top bits read undefined
// RULE_12: Software avoids prohibited conversion time codes
// RULE_13: Result bits 9..2 high, 1..0 low
// RULE_14: Completion stores result, sets flag, interrupt
// RULE_15: Reading result high clears end flag
// RULE_16: Busy follows conversion, cleared in standby
// RULE_17: Result low bits 3..0 read unstable
// RULE_18: Single mode does exactly one conversion
// RULE_19: Repeat mode restarts after each completion
// RULE_20: Mode 00 aborts, partial value discarded
// RULE_21: Bits decided MSB first from comparator
// RULE_22: Start with mode 00 or 10 ignored
*/
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer #(
   parameter int unsigned FC_DIV = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic standby_req,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic comparator,
   output sas_pkg::sas_analog_t analog_out,
   output logic converter_busy_flag,
   output logic conversion_done_irq
);
   import sas_pkg::*;
   // ==========================================================
   // Bus slave
   logic aw_held, next_aw_held, w_held, next_w_held, w_lane, next_w_lane;
   logic [7:0] aw_addr, next_aw_addr, w_byte, next_w_byte, rd_byte;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic wr_fire, ar_fire, rd_clear, wr_mapped, rd_mapped;
   sas_ctrl_one_t ctrl_one, next_ctrl_one;
   sas_ctrl_two_t ctrl_two, next_ctrl_two;
   sas_state_t state, next_state;
   logic [9:0] result, next_result, sar, next_sar, decided;
   logic eoc_flag, next_eoc_flag, irq, next_irq;
   logic [15:0] step_cnt, next_step_cnt, step_len, unit_len;
   logic [3:0] phase, next_phase;
   logic done, step_end, mode_ok;
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign ar_fire = s_axi_arvalid && !rvalid;
   // RULE_15 reading result high
   assign rd_clear = ar_fire && (s_axi_araddr == RESULT_HIGH_ADDR);
   assign wr_mapped = (aw_addr == CTRL_ONE_ADDR) || (aw_addr == CTRL_TWO_ADDR) ||
                      (aw_addr == RESULT_LOW_ADDR) || (aw_addr == RESULT_HIGH_ADDR);
   // Read mux; unstable and undefined bits are driven as zero
   always_comb begin
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         CTRL_ONE_ADDR: rd_byte = ctrl_one;
         // RULE_11 top bits zero
         CTRL_TWO_ADDR: rd_byte = {2'h0, ctrl_two[5:0]};
         // RULE_13 RULE_17 low layout
         RESULT_LOW_ADDR: rd_byte = {result[1:0], eoc_flag, converter_busy_flag, 4'h0};
         RESULT_HIGH_ADDR: rd_byte = result[9:2];
         default: begin
            rd_byte = 8'h00;
            rd_mapped = 1'b0;
         end
      endcase
   end
   // Address and data are taken independently, the write acts when both are held
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_byte = w_byte;
      next_w_lane = w_lane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && s_axi_bready) next_bvalid = 1'b0;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_byte = s_axi_wdata[7:0];
         next_w_lane = s_axi_wstrb[0];
      end
      if (ar_fire) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, rd_byte};
         next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && s_axi_rready) next_rvalid = 1'b0;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h00000000;
      end else if (clk_en) begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_byte <= next_w_byte;
         w_lane <= next_w_lane;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end
   // ==========================================================
   // Control registers
   // RULE_02 RULE_22 valid start modes
   assign mode_ok = (ctrl_one.mode == MODE_SINGLE) || (ctrl_one.mode == MODE_REPEAT);
   always_comb begin
      next_ctrl_one = ctrl_one;
      next_ctrl_two = ctrl_two;
      // RULE_01 start bit lives one cycle
      next_ctrl_one.start = 1'b0;
      if (wr_fire && w_lane && aw_addr == CTRL_ONE_ADDR) next_ctrl_one = w_byte;
      if (wr_fire && w_lane && aw_addr == CTRL_TWO_ADDR) next_ctrl_two = {2'h0, w_byte[5:0]};
      // RULE_07 standby forces reset values
      if (standby_req) begin
         next_ctrl_one = CTRL_ONE_RESET;
         next_ctrl_two = CTRL_TWO_RESET;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_one <= CTRL_ONE_RESET;
         ctrl_two <= CTRL_TWO_RESET;
      end else if (clk_en) begin
         ctrl_one <= next_ctrl_one;
         ctrl_two <= next_ctrl_two;
      end
   end
   // ==========================================================
   // Conversion sequencer
   // RULE_09 unit length per time code; reserved codes take the longest
   always_comb begin
      unique case (ctrl_two.conv_time)
         3'b000: unit_len = UNIT_0;
         3'b010: unit_len = UNIT_2;
         3'b011: unit_len = UNIT_3;
         3'b100: unit_len = UNIT_4;
         3'b101: unit_len = UNIT_5;
         default: unit_len = UNIT_6;
      endcase
   end
   assign step_len = 16'(unit_len * FC_DIV);
   assign step_end = (step_cnt == step_len - 16'h0001);
   // RULE_21 keep trial bit when input is above the DAC
   assign decided = comparator ? sar : (sar & ~(10'h001 << phase));
   always_comb begin
      next_state = state;
      next_step_cnt = step_cnt;
      next_phase = phase;
      next_sar = sar;
      done = 1'b0;
      unique case (state)
         ST_IDLE: begin
            // RULE_01 RULE_18 RULE_22 start only in a valid mode
            if (ctrl_one.start && mode_ok) begin
               next_state = ST_SAMPLE;
               next_step_cnt = 16'h0000;
               next_phase = 4'h0;
               next_sar = 10'h000;
            end
         end
         ST_SAMPLE: begin
            if (step_end) begin
               next_step_cnt = 16'h0000;
               if (phase == 4'(SAMPLE_UNITS - 1)) begin
                  next_state = ST_CONVERT;
                  next_phase = 4'(RESULT_BITS - 1);
                  next_sar = 10'h200;
               end else begin
                  next_phase = phase + 4'h1;
               end
            end else begin
               next_step_cnt = step_cnt + 16'h0001;
            end
         end
         ST_CONVERT: begin
            if (step_end) begin
               next_step_cnt = 16'h0000;
               if (phase == 4'h0) begin
                  done = 1'b1;
                  next_sar = decided;
                  // RULE_19 repeat restarts at once
                  next_state = (ctrl_one.mode == MODE_REPEAT) ? ST_SAMPLE : ST_IDLE;
               end else begin
                  next_phase = phase - 4'h1;
                  next_sar = decided | (10'h001 << (phase - 4'h1));
               end
            end else begin
               next_step_cnt = step_cnt + 16'h0001;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // RULE_20 mode off aborts without storing
      if (state != ST_IDLE && ctrl_one.mode == MODE_OFF) begin
         done = 1'b0;
         next_state = ST_IDLE;
      end
      // RULE_16 standby drops the conversion
      if (standby_req) begin
         done = 1'b0;
         next_state = ST_IDLE;
         next_sar = 10'h000;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         step_cnt <= 16'h0000;
         phase <= 4'h0;
         sar <= 10'h000;
      end else if (clk_en) begin
         state <= next_state;
         step_cnt <= next_step_cnt;
         phase <= next_phase;
         sar <= next_sar;
      end
   end
   // ==========================================================
   // Result, end flag and interrupt
   always_comb begin
      next_result = result;
      next_eoc_flag = eoc_flag;
      next_irq = 1'b0;
      if (rd_clear) next_eoc_flag = 1'b0;
      // RULE_13 RULE_14 store and flag together; set beats the read clear
      if (done) begin
         next_result = next_sar;
         next_eoc_flag = 1'b1;
         next_irq = 1'b1;
      end
      // Earlier results are lost on standby entry
      if (standby_req) begin
         next_result = RESULT_RESET;
         next_eoc_flag = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= RESULT_RESET;
         eoc_flag <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         result <= next_result;
         eoc_flag <= next_eoc_flag;
         irq <= next_irq;
      end
   end
   // ==========================================================
   // Analog side
   // RULE_16 busy from state
   assign converter_busy_flag = (state != ST_IDLE);
   assign conversion_done_irq = irq;
   // RULE_03 RULE_04 input selection
   assign analog_out.channel = ctrl_one.channel;
   assign analog_out.ain_disable = ctrl_one.ain_disable;
   assign analog_out.sample = (state == ST_SAMPLE);
   assign analog_out.dac_code = sar;
   // RULE_08 ladder connection
   assign analog_out.dac_connect = ctrl_two.ladder_connect || converter_busy_flag;
   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);
   a_start_self_clear: assert property ( // RULE_01
      ctrl_one.start && mode_ok && !converter_busy_flag && !standby_req
      && !wr_fire |=> !ctrl_one.start && converter_busy_flag)
      else $error("start bit did not launch a conversion and clear");
   a_bad_mode_idle: assert property ( // RULE_22
      ctrl_one.start && !mode_ok && !converter_busy_flag |=> !converter_busy_flag)
      else $error("conversion started in an invalid mode");
   a_done_flag_irq: assert property ( // RULE_14
      done |=> eoc_flag && conversion_done_irq)
      else $error("completion did not set flag and interrupt");
   a_read_clears_eoc: assert property ( // RULE_15
      rd_clear && !done && !standby_req |=> !eoc_flag)
      else $error("reading result high left the end flag set");
   a_standby_regs: assert property ( // RULE_07
      standby_req |=> ctrl_one == CTRL_ONE_RESET && ctrl_two == CTRL_TWO_RESET)
      else $error("standby did not reset control registers");
   a_standby_busy: assert property ( // RULE_16
      standby_req |=> !converter_busy_flag)
      else $error("busy flag survived standby entry");
   a_ladder_off: assert property ( // RULE_08
      !ctrl_two.ladder_connect && !converter_busy_flag |-> !analog_out.dac_connect)
      else $error("ladder connected outside a conversion");
   a_repeat_next: assert property ( // RULE_19
      done && ctrl_one.mode == MODE_REPEAT |=> analog_out.sample [*3])
      else $error("repeat mode did not restart sampling");
   a_single_stops: assert property ( // RULE_18
      done && ctrl_one.mode == MODE_SINGLE |=> !converter_busy_flag)
      else $error("single mode kept converting");
   a_abort_nostore: assert property ( // RULE_20
      converter_busy_flag && ctrl_one.mode == MODE_OFF && !standby_req
      |=> !converter_busy_flag && $stable(result) && !conversion_done_irq)
      else $error("abort stored a partial result");
   a_result_layout: assert property ( // RULE_13
      done |=> result[9:2] == $past(next_sar[9:2]))
      else $error("result high bits wrong after completion");
   a_msb_first: assert property ( // RULE_21
      state == ST_SAMPLE && next_state == ST_CONVERT |=> sar == 10'h200)
      else $error("search did not start at the top bit");
endmodule : sas_sequencer
`default_nettype wire

// File: inc/sas_pkg.sv
/*
 Shared constants and types for the SAR converter sequencer: register
 indices and byte addresses, reset values, field layouts, modes, states
 and conversion step lengths.
 Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
package sas_pkg;

   // ==========================================================
   // Register map: printed offsets are indices, byte address = 4 * index
   localparam logic [7:0] CTRL_ONE_IDX = 8'h1c;
   localparam logic [7:0] CTRL_TWO_IDX = 8'h1d;
   localparam logic [7:0] RESULT_LOW_IDX = 8'h1e;
   localparam logic [7:0] RESULT_HIGH_IDX = 8'h1f;
   localparam logic [7:0] CTRL_ONE_ADDR = 8'h70;
   localparam logic [7:0] CTRL_TWO_ADDR = 8'h74;
   localparam logic [7:0] RESULT_LOW_ADDR = 8'h78;
   localparam logic [7:0] RESULT_HIGH_ADDR = 8'h7c;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_ONE_RESET = 8'h10;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h10;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   // ==========================================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Modes, states and field layouts
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_RSVD = 2'b10,
      MODE_REPEAT = 2'b11
   } sas_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } sas_state_t;

   typedef struct packed {
      logic start;
      sas_mode_t mode;
      logic ain_disable;
      logic [3:0] channel;
   } sas_ctrl_one_t;

   typedef struct packed {
      logic [1:0] top;
      logic ladder_connect;
      logic fixed_one;
      logic [2:0] conv_time;
      logic fixed_zero;
   } sas_ctrl_two_t;

   typedef struct packed {
      logic [3:0] channel;
      logic ain_disable;
      logic sample;
      logic [9:0] dac_code;
      logic dac_connect;
   } sas_analog_t;

   // ==========================================================
   // Conversion timing in main-clock periods, split into 13 equal units:
   // 3 units of sampling and one unit per result bit
   localparam int unsigned RESULT_BITS = 10;
   localparam int unsigned SAMPLE_UNITS = 3;
   localparam int unsigned UNITS_PER_CONV = 13;
   localparam int unsigned CONV_PERIODS_0 = 39;
   localparam int unsigned CONV_PERIODS_2 = 78;
   localparam int unsigned CONV_PERIODS_3 = 156;
   localparam int unsigned CONV_PERIODS_4 = 312;
   localparam int unsigned CONV_PERIODS_5 = 624;
   localparam int unsigned CONV_PERIODS_6 = 1248;
   localparam logic [15:0] UNIT_0 = 16'(CONV_PERIODS_0 / UNITS_PER_CONV);
   localparam logic [15:0] UNIT_2 = 16'(CONV_PERIODS_2 / UNITS_PER_CONV);
   localparam logic [15:0] UNIT_3 = 16'(CONV_PERIODS_3 / UNITS_PER_CONV);
   localparam logic [15:0] UNIT_4 = 16'(CONV_PERIODS_4 / UNITS_PER_CONV);
   localparam logic [15:0] UNIT_5 = 16'(CONV_PERIODS_5 / UNITS_PER_CONV);
   localparam logic [15:0] UNIT_6 = 16'(CONV_PERIODS_6 / UNITS_PER_CONV);

endpackage : sas_pkg

// File: verification/sas_analog_model.sv
/*
 Behavioural model of the analog side: input mux, ladder DAC
 and comparator. Assumes the sequencer drives analog_out and samples the
 comparator at the end of each step; levels come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module sas_analog_model (
   input wire logic aclk,
   input wire logic slow,
   input wire logic [15:0][9:0] levels,
   input wire sas_pkg::sas_analog_t analog_out,
   output logic comparator
);
   import sas_pkg::*;
   logic fast_cmp;
   logic late_cmp;
   logic toggle = 1'b0;
   // ==========================================================
   // Comparator
   // mux and input disable
   // Input sits half a step above its level, so equal codes keep the bit
   always_comb begin
      if (analog_out.ain_disable) begin
         fast_cmp = 1'b0;
      end else begin
         fast_cmp = levels[analog_out.channel] >= analog_out.dac_code;
      end
   end
   // Slow answer lags one cycle; a released ladder gives a wandering output
   always_ff @(posedge aclk) begin
      late_cmp <= fast_cmp;
      toggle <= ~toggle;
   end
   // ladder off means no valid compare
   assign comparator = !analog_out.dac_connect ? toggle : (slow ? late_cmp : fast_cmp);
endmodule : sas_analog_model

`default_nettype wire

// File: verification/tb.sv
/*
 Self-checking bench for the converter sequencer over AXI4-Lite.
 Assumes the analog model stands on the far side and clk_en stays high.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   import sas_pkg::*;
   typedef struct {
      logic [3:0] ch;
      logic [2:0] code;
      logic [9:0] lvl;
      logic slw;
      int len;
   } sas_row_t;
   logic aclk, aresetn, standby_req, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, comparator, converter_busy_flag, conversion_done_irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0][9:0] levels;
   sas_analog_t analog_out;
   int errors, n_checks, busy_run, last_run, irq_cnt, n0, t;
   // Ordinary cases: channel, time code, level, slow compare, periods
   sas_row_t rows [6] = '{
      '{4'h0, 3'h0, 10'h3ff, 1'b0, 39}, '{4'h5, 3'h2, 10'h000, 1'b1, 78},
      '{4'h9, 3'h3, 10'h2a5, 1'b0, 156}, '{4'hf, 3'h4, 10'h15a, 1'b1, 312},
      '{4'h3, 3'h5, 10'h201, 1'b0, 624}, '{4'hc, 3'h6, 10'h1ff, 1'b0, 1248}};

   sas_sequencer #(.FC_DIV(1)) i_sas_sequencer (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .standby_req(standby_req),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .comparator(comparator),
      .analog_out(analog_out), .converter_busy_flag(converter_busy_flag),
      .conversion_done_irq(conversion_done_irq));
   sas_analog_model i_sas_analog_model (.aclk(aclk), .slow(slow), .levels(levels),
      .analog_out(analog_out), .comparator(comparator));

   // ==========================================================
   // Clock, monitors and helpers
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Busy run length and done pulses, counted apart from the tests
   always @(posedge aclk) begin
      if (converter_busy_flag === 1'b1) begin
         busy_run <= busy_run + 1;
      end else if (busy_run != 0) begin
         last_run <= busy_run;
         busy_run <= 0;
      end
      if (conversion_done_irq === 1'b1) begin
         irq_cnt <= irq_cnt + 1;
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Write: both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, v};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      rs = 2'h3;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            rs = s_axi_bresp;
            k = 1000;
         end
      end
      s_axi_bready <= 1'b0;
      if (k == 200) errors++;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rs = 2'h3;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            v = s_axi_rdata;
            rs = s_axi_rresp;
            k = 1000;
         end
      end
      s_axi_rready <= 1'b0;
      if (k == 200) errors++;
   endtask : rd
   // Bounded wait for the end of a conversion, then let flags land
   task automatic wait_idle();
      int k;
      repeat (4) @(posedge aclk);
      for (k = 0; k < 3000 && converter_busy_flag !== 1'b0; k++) @(posedge aclk);
      if (k == 3000) errors++;
      repeat (3) @(posedge aclk);
   endtask : wait_idle
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      results();
   end

   // ==========================================================
   // Tests
   initial begin
      {aresetn, standby_req, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      for (int i = 0; i < 16; i++) levels[i] = {4'(i), 6'h15};
      do_reset();
      foreach (rows[i]) begin
         levels[rows[i].ch] <= rows[i].lvl;
         slow <= rows[i].slw;
         wr(CTRL_TWO_ADDR, {4'h1, rows[i].code, 1'b0}, r);
         wr(CTRL_ONE_ADDR, {4'h2, rows[i].ch}, r);
         chk("channel", 32'(analog_out.channel), 32'(rows[i].ch));
         n0 = irq_cnt;
         wr(CTRL_ONE_ADDR, {4'ha, rows[i].ch}, r);
         wait_idle();
         t = rows[i].len;
         chk("length", 32'(last_run >= t - 1 && last_run <= t + 1), 32'h1);
         chk("done count", 32'(irq_cnt - n0), 32'h1);
         rd(RESULT_LOW_ADDR, d, r);
         chk("low", d & 32'hf0, 32'({rows[i].lvl[1:0], 6'h20}));
         rd(RESULT_HIGH_ADDR, d, r);
         chk("high", d, 32'(rows[i].lvl[9:2]));
         rd(RESULT_LOW_ADDR, d, r);
         chk("end flag", d & 32'h20, 32'h0);
         rd(CTRL_ONE_ADDR, d, r);
         chk("start clear", d, 32'({4'h2, rows[i].ch}));
         $display("row %0d done", i);
      end
      // Second reset while idle, then register reset values
      do_reset();
      rd(CTRL_ONE_ADDR, d, r);
      chk("ctrl one rst", d, 32'h10);
      rd(CTRL_TWO_ADDR, d, r);
      chk("ctrl two rst", d & 32'h3f, 32'h10);
      rd(RESULT_HIGH_ADDR, d, r);
      chk("high rst", d, 32'h0);
      chk("ladder rst", 32'(analog_out.dac_connect), 32'h0);
      rd(8'h00, d, r);
      chk("unmapped rd", {d[29:0], r}, 32'(RESP_SLVERR));
      wr(8'h40, 8'h55, r);
      chk("unmapped wr", 32'(r), 32'(RESP_SLVERR));
      wr(RESULT_HIGH_ADDR, 8'hff, r);
      rd(RESULT_HIGH_ADDR, d, r);
      chk("ro high", d, 32'h0);
      $display("reset and map test done");
      // Start refused with mode off or reserved
      foreach (rows[i]) begin
         if (i < 2) begin
            n0 = irq_cnt;
            wr(CTRL_ONE_ADDR, {1'b1, 1'(i), 2'b00, 4'h1}, r);
            repeat (60) @(posedge aclk);
            chk("no start", 32'({converter_busy_flag, 8'(irq_cnt - n0)}), 32'h0);
         end
      end
      $display("refused start test done");
      // Repeat, then abort mid-conversion with a changed input
      levels[2] <= 10'h155;
      n0 = irq_cnt;
      wr(CTRL_ONE_ADDR, 8'he2, r);
      for (t = 0; t < 400 && irq_cnt < n0 + 3; t++) @(posedge aclk);
      @(posedge aclk);
      chk("repeat count", 32'(irq_cnt - n0 >= 3), 32'h1);
      chk("repeat busy", 32'(converter_busy_flag), 32'h1);
      chk("ladder busy", 32'(analog_out.dac_connect), 32'h1);
      levels[2] <= 10'h2aa;
      repeat (20) @(posedge aclk);
      wr(CTRL_ONE_ADDR, 8'h02, r);
      repeat (3) @(posedge aclk);
      chk("abort busy", 32'(converter_busy_flag), 32'h0);
      n0 = irq_cnt;
      repeat (60) @(posedge aclk);
      rd(RESULT_HIGH_ADDR, d, r);
      chk("abort keep", {d[23:0], 8'(irq_cnt - n0)}, 32'h5500);
      wr(CTRL_TWO_ADDR, 8'h30, r);
      chk("ladder on", 32'(analog_out.dac_connect), 32'h1);
      $display("repeat test done");
      // Standby in mid-conversion
      wr(CTRL_TWO_ADDR, 8'h1c, r);
      wr(CTRL_ONE_ADDR, 8'ha7, r);
      repeat (100) @(posedge aclk);
      n0 = irq_cnt;
      standby_req <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("standby busy", 32'(converter_busy_flag), 32'h0);
      wr(CTRL_ONE_ADDR, 8'h23, r);
      rd(CTRL_ONE_ADDR, d, r);
      chk("standby ctrl one", d, 32'h10);
      rd(CTRL_TWO_ADDR, d, r);
      chk("standby ctrl two", d & 32'h3f, 32'h10);
      standby_req <= 1'b0;
      rd(RESULT_HIGH_ADDR, d, r);
      chk("standby result", {d[23:0], 8'(irq_cnt - n0)}, 32'h0);
      wr(CTRL_ONE_ADDR, 8'h1f, r);
      chk("inputs off", 32'(analog_out.ain_disable), 32'h1);
      wr(CTRL_ONE_ADDR, 8'h0f, r);
      chk("inputs on", 32'(analog_out.ain_disable), 32'h0);
      $display("standby test done");
      results();
   end
endmodule : tb

`default_nettype wire
